// ==== pfsa_pkg.sv ====
package pfsa_pkg;

  // ****************************************************************
  // link register map (index on the core access path)
  // ****************************************************************
  localparam logic [2:0] ADDR_LOW_IDX  = 3'h0;
  localparam logic [2:0] ADDR_HIGH_IDX = 3'h1;
  localparam logic [2:0] WORD_LOW_IDX  = 3'h2;
  localparam logic [2:0] WORD_HIGH_IDX = 3'h3;
  localparam logic [2:0] CTRL1_IDX     = 3'h4;
  localparam logic [2:0] UNLOCK_IDX    = 3'h5;

  // ctrl1 field positions
  localparam int READ_GO_BIT   = 0;
  localparam int PROG_GO_BIT   = 1;
  localparam int PROG_EN_BIT   = 2;
  localparam int ERASE_SEL_BIT = 4;
  localparam int LATCH_ONLY_BIT = 5;
  localparam int CFG_SEL_BIT   = 6;

  // reset values and keys
  localparam logic [7:0]  CTRL1_RESET  = 8'h00;
  localparam logic [7:0]  REG_RESET    = 8'h00;
  localparam logic [7:0]  UNLOCK_KEY1  = 8'h55;
  localparam logic [7:0]  UNLOCK_KEY2  = 8'haa;
  localparam logic [13:0] LATCH_BLANK  = 14'h3fff;

  // sizes
  localparam int WORD_W    = 14;
  localparam int ADDR_W    = 15;
  localparam int LATCH_N   = 32;
  localparam int LATCH_IW  = 5;

  // timing
  localparam int CLK_MHZ       = 100;
  localparam int ERASE_TIME_US = 2000;
  localparam int ERASE_CYC     = ERASE_TIME_US * CLK_MHZ;
  localparam int CLK_PER_ICYC  = 4;

  // host wishbone map
  localparam logic [7:0] CMD_OFS  = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam int CMD_IDX_LSB  = 0;
  localparam int CMD_DATA_LSB = 8;
  localparam int CMD_WE_BIT   = 16;
  localparam int CMD_NOP_BIT  = 17;
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_HOLD_BIT  = 1;
  localparam int ST_VOID_BIT  = 2;
  localparam int ST_RDATA_LSB = 8;

  typedef enum {OP_NONE, OP_LATCH, OP_ERASE, OP_PROG} pfsa_op_t;

endpackage : pfsa_pkg

// ==== pfsa_if.sv ====
`timescale 1ns/100ps
interface pfsa_if;
  logic       icyc;       // one instruction cycle, pulse
  logic       acc_valid;  // slot carries a register access
  logic       acc_we;
  logic [2:0] acc_idx;
  logic [7:0] acc_wdata;
  logic [7:0] acc_rdata;  // answer, one clock after icyc
  logic       slot_void;  // current slot is forced to nop
  logic       core_hold;  // execution stalled

  modport dev  (input icyc, acc_valid, acc_we, acc_idx, acc_wdata,
                output acc_rdata, slot_void, core_hold);
  modport core (output icyc, acc_valid, acc_we, acc_idx, acc_wdata,
                input acc_rdata, slot_void, core_hold);
endinterface : pfsa_if

// ==== pfsa_tmr.sv ====
`timescale 1ns/100ps
module pfsa_tmr #(
  parameter int CNT_W = 18
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] count,
  output logic                  done
);
  import pfsa_pkg::*;

  typedef struct packed {
    logic             run;
    logic [CNT_W-1:0] cnt;
    logic             done;
  } pfsa_tmr_st_t;

  pfsa_tmr_st_t st_r, st_nxt;

  initial begin
    if (CNT_W < 2) $error("pfsa_tmr: CNT_W too small");
  end

  // countdown, done pulses once as the count reaches one
  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    if (load) begin
      st_nxt.run = 1'b1;
      st_nxt.cnt = count;
    end else if (st_r.run) begin
      if (st_r.cnt <= CNT_W'(1)) begin
        st_nxt.run  = 1'b0;
        st_nxt.done = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) st_r <= '0;
    else       st_r <= st_nxt;
  end

  assign done = st_r.done;

endmodule : pfsa_tmr

// ==== pfsa_dev.sv ====
// Notes on behaviour
// - software loads address, clears config, sets read_go
// - second slot after read_go does array read
// - word appears in data pair right after read
// - data pair holds until next read/write
// - software puts nops after read_go
// - erase, latch load, program need full unlock
// - unlock: 55h, AAh, program_go, two nops
// - program_go always forces two nop slots
// - erase or program stalls core until done
// - latch load: two nops, then no stall
// - software masks interrupts around unlock
// - erase only whole rows
// - erase setup order by software
// - stall halts execution only, clocks run
// - resume at third slot after program_go
// - go bits software-set only, hardware clears
// - write/erase need program_enable, clear at reset
// - 14-bit word, 15-bit address
// - latches go blank after write or erase
//
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module pfsa_dev #(
  parameter int ERASE_CYCLES = pfsa_pkg::ERASE_CYC
) (
  input  wire logic                          CLK,
  input  wire logic                          RESET,
  pfsa_if.dev                                LINK,
  output logic [pfsa_pkg::ADDR_W-1:0]        ARR_ADDR,
  output logic                               ARR_RD,
  input  wire logic [pfsa_pkg::WORD_W-1:0]   ARR_RWORD,
  output logic                               ARR_ERASE,
  output logic                               ARR_PROG,
  input  wire logic [pfsa_pkg::LATCH_IW-1:0] ARR_WIDX,
  output logic [pfsa_pkg::WORD_W-1:0]        ARR_WDATA,
  output logic                               ARR_BUSY
);
  import pfsa_pkg::*;

  localparam int TMR_W = $clog2(ERASE_CYCLES + 1) + 1;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum {S_IDLE, S_RD1, S_RD2, S_RDW, S_NOP1, S_NOP2, S_STALL} pfsa_seq_t;
  typedef enum {U_IDLE, U_KEY1, U_KEY2} pfsa_unl_t;

  typedef struct packed {
    pfsa_seq_t                          seq;
    pfsa_unl_t                          unl;
    pfsa_op_t                           op;
    logic [7:0]                         addr_low;
    logic [ADDR_W-9:0]                  addr_high;
    logic [7:0]                         word_low;
    logic [WORD_W-9:0]                  word_high;
    logic [7:0]                         ctrl1;
    logic [LATCH_N-1:0][WORD_W-1:0]     latch;
    logic [7:0]                         rdata;
    logic                               slot_void;
    logic                               hold;
    logic                               arr_rd;
    logic                               arr_erase;
    logic                               arr_prog;
    logic [WORD_W-1:0]                  wdata;
  } pfsa_dev_st_t;

  pfsa_dev_st_t st_r, st_nxt;
  logic         tmr_load;
  logic         tmr_done;
  logic         slot_live;
  logic [7:0]   wd;

  initial begin
    if (ERASE_CYCLES < 1) $error("pfsa_dev: ERASE_CYCLES must be positive");
  end

  // ****************************************************************
  // stall timer for erase and row program
  // ****************************************************************
  pfsa_tmr #(.CNT_W(TMR_W)) u_tmr (
    .clk   (CLK),
    .reset (RESET),
    .load  (tmr_load),
    .count (TMR_W'(ERASE_CYCLES)),
    .done  (tmr_done)
  );

  // a slot whose access is really executed
  assign slot_live = LINK.icyc && LINK.acc_valid && !st_r.slot_void;
  assign wd        = LINK.acc_wdata;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_nxt           = st_r;
    st_nxt.arr_rd    = 1'b0;
    st_nxt.arr_erase = 1'b0;
    st_nxt.arr_prog  = 1'b0;
    tmr_load         = 1'b0;

    // read mux, unlock register reads as zero
    case (LINK.acc_idx)
      ADDR_LOW_IDX:  st_nxt.rdata = st_r.addr_low;
      ADDR_HIGH_IDX: st_nxt.rdata = {1'b0, st_r.addr_high};
      WORD_LOW_IDX:  st_nxt.rdata = st_r.word_low;
      WORD_HIGH_IDX: st_nxt.rdata = {2'b00, st_r.word_high};
      CTRL1_IDX:     st_nxt.rdata = st_r.ctrl1;
      default:       st_nxt.rdata = 8'h00;
    endcase

    // plain register writes
    if (slot_live && LINK.acc_we) begin
      case (LINK.acc_idx)
        ADDR_LOW_IDX:  st_nxt.addr_low  = wd;
        ADDR_HIGH_IDX: st_nxt.addr_high = wd[ADDR_W-9:0];
        WORD_LOW_IDX:  st_nxt.word_low  = wd;
        WORD_HIGH_IDX: st_nxt.word_high = wd[WORD_W-9:0];
        CTRL1_IDX: begin
          // go bits kept here, set only by the sequencer, never cleared by software
          st_nxt.ctrl1 = {wd[7:2], st_r.ctrl1[PROG_GO_BIT:READ_GO_BIT]};
        end
        default: ;
      endcase
    end

    // unlock tracker, any stray access drops it
    if (slot_live) begin
      case (st_r.unl)
        U_IDLE: begin
          if (LINK.acc_we && LINK.acc_idx == UNLOCK_IDX && wd == UNLOCK_KEY1)
            st_nxt.unl = U_KEY1;
        end
        U_KEY1: begin
          if (LINK.acc_we && LINK.acc_idx == UNLOCK_IDX && wd == UNLOCK_KEY2)
            st_nxt.unl = U_KEY2;
          else
            st_nxt.unl = U_IDLE;
        end
        U_KEY2:  st_nxt.unl = U_IDLE;
        default: st_nxt.unl = U_IDLE;
      endcase
    end

    // sequencer
    case (st_r.seq)
      S_IDLE: begin
        if (slot_live && LINK.acc_we && LINK.acc_idx == CTRL1_IDX) begin
          if (wd[PROG_GO_BIT]) begin
            st_nxt.ctrl1[PROG_GO_BIT] = 1'b1;
            st_nxt.slot_void = 1'b1;
            st_nxt.seq       = S_NOP1;
            // operation needs enable, unlock pair and program space
            if (st_r.unl == U_KEY2 && wd[PROG_EN_BIT] && !wd[CFG_SEL_BIT]) begin
              if (wd[ERASE_SEL_BIT])       st_nxt.op = OP_ERASE;
              else if (wd[LATCH_ONLY_BIT]) st_nxt.op = OP_LATCH;
              else                         st_nxt.op = OP_PROG;
            end else begin
              st_nxt.op = OP_NONE;
            end
          end else if (wd[READ_GO_BIT]) begin
            st_nxt.ctrl1[READ_GO_BIT] = 1'b1;
            st_nxt.seq = S_RD1;
          end
        end
      end
      S_RD1: begin
        // first slot after read_go executes normally
        if (LINK.icyc) begin
          st_nxt.slot_void = 1'b1;
          st_nxt.seq       = S_RD2;
        end
      end
      S_RD2: begin
        // second slot is taken for the array read
        if (LINK.icyc) begin
          st_nxt.arr_rd    = 1'b1;
          st_nxt.slot_void = 1'b0;
          st_nxt.seq       = S_RDW;
        end
      end
      S_RDW: begin
        st_nxt.word_low            = ARR_RWORD[7:0];
        st_nxt.word_high           = ARR_RWORD[WORD_W-1:8];
        st_nxt.ctrl1[READ_GO_BIT]  = 1'b0;
        st_nxt.seq                 = S_IDLE;
      end
      S_NOP1: begin
        if (LINK.icyc) st_nxt.seq = S_NOP2;
      end
      S_NOP2: begin
        if (LINK.icyc) begin
          st_nxt.slot_void = 1'b0;
          case (st_r.op)
            OP_ERASE, OP_PROG: begin
              // whole row only, address low bits ignored by array
              st_nxt.arr_erase = (st_r.op == OP_ERASE);
              st_nxt.arr_prog  = (st_r.op == OP_PROG);
              st_nxt.hold      = 1'b1;
              tmr_load         = 1'b1;
              st_nxt.seq       = S_STALL;
            end
            OP_LATCH: begin
              st_nxt.latch[st_r.addr_low[LATCH_IW-1:0]] = {st_r.word_high, st_r.word_low};
              st_nxt.ctrl1[PROG_GO_BIT] = 1'b0;
              st_nxt.seq = S_IDLE;
            end
            default: begin
              st_nxt.ctrl1[PROG_GO_BIT] = 1'b0;
              st_nxt.seq = S_IDLE;
            end
          endcase
        end
      end
      S_STALL: begin
        if (tmr_done) begin
          st_nxt.hold  = 1'b0;
          st_nxt.latch = {LATCH_N{LATCH_BLANK}};
          st_nxt.ctrl1[PROG_GO_BIT] = 1'b0;
          st_nxt.op  = OP_NONE;
          st_nxt.seq = S_IDLE;
        end
      end
      default: st_nxt.seq = S_IDLE;
    endcase

    // row data for the array, registered
    st_nxt.wdata = st_r.latch[ARR_WIDX];
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (RESET) begin
      st_r           <= '0;
      st_r.seq       <= S_IDLE;
      st_r.unl       <= U_IDLE;
      st_r.op        <= OP_NONE;
      st_r.ctrl1     <= CTRL1_RESET;
      st_r.addr_low  <= REG_RESET;
      st_r.word_low  <= REG_RESET;
      st_r.latch     <= {LATCH_N{LATCH_BLANK}};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign LINK.acc_rdata = st_r.rdata;
  assign LINK.slot_void = st_r.slot_void;
  assign LINK.core_hold = st_r.hold;
  assign ARR_ADDR       = {st_r.addr_high, st_r.addr_low};
  assign ARR_RD         = st_r.arr_rd;
  assign ARR_ERASE      = st_r.arr_erase;
  assign ARR_PROG       = st_r.arr_prog;
  assign ARR_WDATA      = st_r.wdata;
  assign ARR_BUSY       = st_r.hold;

endmodule : pfsa_dev

// ==== pfsa_core.sv ====
`timescale 1ns/100ps
module pfsa_core #(
  parameter int ICYC_CLKS = pfsa_pkg::CLK_PER_ICYC
) (
  input  wire logic        CLK,
  input  wire logic        RESET,
  pfsa_if.core             LINK,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic [31:0]      WB_DAT_O,
  output logic             WB_ACK_O
);
  import pfsa_pkg::*;

  localparam int DIV_W = $clog2(ICYC_CLKS) + 1;

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic             icyc;
    logic             busy;
    logic             p_nop;
    logic             p_we;
    logic [2:0]       p_idx;
    logic [7:0]       p_data;
    logic             valid;
    logic             we;
    logic [2:0]       idx;
    logic [7:0]       wdata;
    logic             rcap;
    logic [7:0]       rdata;
    logic             voided;
    logic             ack;
    logic [31:0]      dat;
  } pfsa_core_st_t;

  pfsa_core_st_t st_r, st_nxt;
  logic          wb_req;
  logic          wr_cmd;
  logic          wr_stat;

  initial begin
    if (ICYC_CLKS < 2) $error("pfsa_core: ICYC_CLKS must be at least 2");
  end

  assign wb_req  = WB_CYC_I && WB_STB_I && !st_r.ack;
  assign wr_cmd  = wb_req && WB_WE_I && WB_ADR_I == CMD_OFS && (&WB_SEL_I[2:0]);
  assign wr_stat = wb_req && WB_WE_I && WB_ADR_I == STAT_OFS && WB_SEL_I[0];

  // ****************************************************************
  // slot generation, bus slave
  // ****************************************************************
  always_comb begin
    st_nxt       = st_r;
    st_nxt.icyc  = 1'b0;
    st_nxt.valid = 1'b0;
    st_nxt.rcap  = 1'b0;
    st_nxt.ack   = wb_req;

    // instruction cycle divider, frozen while stalled
    if (!LINK.core_hold) begin
      if (st_r.div == '0) begin
        st_nxt.div  = DIV_W'(ICYC_CLKS - 1);
        st_nxt.icyc = 1'b1;
        if (st_r.busy) begin
          st_nxt.busy  = 1'b0;
          st_nxt.valid = !st_r.p_nop;
          st_nxt.we    = st_r.p_we;
          st_nxt.idx   = st_r.p_idx;
          st_nxt.wdata = st_r.p_data;
        end
      end else begin
        st_nxt.div = st_r.div - DIV_W'(1);
      end
    end

    // slot seen by the device this clock
    if (st_r.icyc && st_r.valid) begin
      if (LINK.slot_void) st_nxt.voided = 1'b1;
      else if (!st_r.we)  st_nxt.rcap   = 1'b1;
    end
    if (st_r.rcap) st_nxt.rdata = LINK.acc_rdata;

    // write one to clear, a new event wins
    if (wr_stat && WB_DAT_I[ST_VOID_BIT] && !(st_r.icyc && st_r.valid && LINK.slot_void))
      st_nxt.voided = 1'b0;

    // new instruction taken only when idle
    if (wr_cmd && !st_r.busy) begin
      st_nxt.busy   = 1'b1;
      st_nxt.p_nop  = WB_DAT_I[CMD_NOP_BIT];
      st_nxt.p_we   = WB_DAT_I[CMD_WE_BIT];
      st_nxt.p_idx  = WB_DAT_I[CMD_IDX_LSB +: 3];
      st_nxt.p_data = WB_DAT_I[CMD_DATA_LSB +: 8];
    end

    // read answer
    st_nxt.dat = 32'h0000_0000;
    if (wb_req && !WB_WE_I) begin
      case (WB_ADR_I)
        CMD_OFS: begin
          st_nxt.dat[CMD_IDX_LSB +: 3]  = st_r.p_idx;
          st_nxt.dat[CMD_DATA_LSB +: 8] = st_r.p_data;
          st_nxt.dat[CMD_WE_BIT]        = st_r.p_we;
          st_nxt.dat[CMD_NOP_BIT]       = st_r.p_nop;
        end
        STAT_OFS: begin
          st_nxt.dat[ST_BUSY_BIT]        = st_r.busy || st_r.icyc || st_r.rcap;
          st_nxt.dat[ST_HOLD_BIT]        = LINK.core_hold;
          st_nxt.dat[ST_VOID_BIT]        = st_r.voided;
          st_nxt.dat[ST_RDATA_LSB +: 8]  = st_r.rdata;
        end
        default: st_nxt.dat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) st_r <= '0;
    else       st_r <= st_nxt;
  end

  assign LINK.icyc      = st_r.icyc;
  assign LINK.acc_valid = st_r.valid;
  assign LINK.acc_we    = st_r.we;
  assign LINK.acc_idx   = st_r.idx;
  assign LINK.acc_wdata = st_r.wdata;
  assign WB_DAT_O       = st_r.dat;
  assign WB_ACK_O       = st_r.ack;

endmodule : pfsa_core

// ==== pfsa_asserts.sv ====
`timescale 1ns/100ps
module pfsa_asserts (
  input wire logic       CLK,
  input wire logic       RESET,
  input wire logic       icyc,
  input wire logic       acc_valid,
  input wire logic       acc_we,
  input wire logic [2:0] acc_idx,
  input wire logic [7:0] acc_wdata,
  input wire logic [7:0] acc_rdata,
  input wire logic       slot_void,
  input wire logic       core_hold
);
  import pfsa_pkg::*;
  // ****************************************************************
  // unlock tracking
  // ****************************************************************
  logic [1:0] stg_r;
  logic       live, wr5, go, rgo, armed;
  // live slots only, nops leave the tracker alone
  assign live  = icyc & acc_valid & ~slot_void & ~core_hold;
  assign wr5   = live & acc_we & (acc_idx == UNLOCK_IDX);
  assign go    = live & acc_we & (acc_idx == CTRL1_IDX) & acc_wdata[PROG_GO_BIT];
  assign rgo   = live & acc_we & (acc_idx == CTRL1_IDX) & acc_wdata[READ_GO_BIT];
  assign armed = (stg_r == 2'h2) & acc_wdata[PROG_EN_BIT] & ~acc_wdata[CFG_SEL_BIT];
  // key stage after each live access
  always_ff @(posedge CLK) begin
    if (RESET) begin
      stg_r <= 2'h0;
    end else if (live) begin
      stg_r <= (wr5 && stg_r == 2'h0 && acc_wdata == UNLOCK_KEY1) ? 2'h1 :
               (wr5 && stg_r == 2'h1 && acc_wdata == UNLOCK_KEY2) ? 2'h2 : 2'h0;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  // ****************************************************************
  // checks
  // ****************************************************************
  a_go_two_void: assert property (go |=> (!icyc)[*3] ##1 (icyc && slot_void) ##1 (!icyc)[*3]
    ##1 (icyc && slot_void)) else $error("program go did not void two slots");
  a_read_slot_void: assert property (rgo |=> ##3 (icyc && !slot_void) ##4 (icyc && slot_void))
    else $error("read start did not void the second slot");
  a_unlock_reads_zero: assert property (live && !acc_we && acc_idx == UNLOCK_IDX |=> acc_rdata == 8'h00)
    else $error("unlock register read not zero");
  a_erase_stalls: assert property (go && armed && acc_wdata[ERASE_SEL_BIT] && !acc_wdata[LATCH_ONLY_BIT]
    |-> ##[6:14] core_hold) else $error("armed erase gave no stall");
  a_latch_no_stall: assert property (go && armed && acc_wdata[LATCH_ONLY_BIT] && !acc_wdata[ERASE_SEL_BIT]
    |=> (!core_hold)[*8] ##1 (!core_hold)[*6]) else $error("latch load stalled");
  a_unarmed_idle: assert property (go && !armed |=> (!core_hold)[*8] ##1 (!core_hold)[*6])
    else $error("unarmed go started an operation");
  a_hold_min_len: assert property ($rose(core_hold) |-> core_hold[*8])
    else $error("stall too short");
  a_hold_ends: assert property ($rose(core_hold) |-> ##[1:60] !core_hold)
    else $error("stall did not end");
  a_hold_no_slot: assert property (core_hold |-> !icyc)
    else $error("slot issued during stall");
endmodule : pfsa_asserts

// ==== tb_program_flash_self_access.sv ====
`timescale 1ns/100ps
module tb_program_flash_self_access;
  import pfsa_pkg::*;
  localparam int ECYC = 20;
  logic                CLK, RESET, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O;
  logic [7:0]          WB_ADR_I;
  logic [3:0]          WB_SEL_I;
  logic [31:0]         WB_DAT_I, WB_DAT_O, rd;
  logic [ADDR_W-1:0]   ARR_ADDR, erase_adr;
  logic                ARR_RD, ARR_ERASE, ARR_PROG, ARR_BUSY;
  logic [WORD_W-1:0]   ARR_RWORD, ARR_WDATA;
  logic [LATCH_IW-1:0] ARR_WIDX;
  int                  n_fail, samples_checked, erase_cnt, hold_cnt, a, w, k, h, e;
  int                  rd_cnt, prog_cnt, busy_cnt, b;
  int                  mreg[8];
  bit                  skip;
  pfsa_if link ();
  pfsa_dev #(.ERASE_CYCLES(ECYC)) pfsa_dev_inst (.CLK(CLK), .RESET(RESET), .LINK(link),
    .ARR_ADDR(ARR_ADDR), .ARR_RD(ARR_RD), .ARR_RWORD(ARR_RWORD), .ARR_ERASE(ARR_ERASE),
    .ARR_PROG(ARR_PROG), .ARR_WIDX(ARR_WIDX), .ARR_WDATA(ARR_WDATA), .ARR_BUSY(ARR_BUSY));
  pfsa_core pfsa_core_inst (.CLK(CLK), .RESET(RESET), .LINK(link), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
    .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O));
  pfsa_asserts pfsa_asserts_inst (.CLK(CLK), .RESET(RESET), .icyc(link.icyc), .acc_valid(link.acc_valid),
    .acc_we(link.acc_we), .acc_idx(link.acc_idx), .acc_wdata(link.acc_wdata), .acc_rdata(link.acc_rdata),
    .slot_void(link.slot_void), .core_hold(link.core_hold));
  // array content model
  function automatic int mem_word(input int ad);
    return (ad * 37 + 11) & 16'h3fff;
  endfunction : mem_word
  assign ARR_RWORD = 14'(mem_word(int'(ARR_ADDR)));
  always #5 CLK = ~CLK;
  // array side monitor
  always @(posedge CLK) begin
    if (ARR_ERASE === 1'b1) begin
      erase_cnt++;
      erase_adr = ARR_ADDR;
    end
    if (link.core_hold === 1'b1) hold_cnt++;
    if (ARR_RD === 1'b1) rd_cnt++;
    if (ARR_PROG === 1'b1) prog_cnt++;
    if (ARR_BUSY === 1'b1) busy_cnt++;
  end
  task end_sim;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one classic wishbone cycle
  task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int i;
    @(posedge CLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I  <= we;
    WB_ADR_I <= adr;
    WB_DAT_I <= dat;
    WB_SEL_I <= 4'hf;
    for (i = 0; i < 20 && WB_ACK_O !== 1'b1; i++) @(posedge CLK);
    if (WB_ACK_O !== 1'b1) begin
      n_fail++;
      end_sim();
    end else begin
      rd = WB_DAT_O;
      WB_CYC_I <= 1'b0;
      WB_STB_I <= 1'b0;
    end
  endtask : wb
  // one slot command, model update, wait till executed
  task cmd(input logic [2:0] idx, input logic [7:0] d, input logic we, input logic nop);
    int i;
    if (we && !nop && !skip && idx < 5)
      mreg[idx] = d & ((idx == 1) ? 8'h7f : (idx == 3) ? 8'h3f : (idx == 4) ? 8'hfc : 8'hff);
    if (we && !nop && !skip && idx == 4 && d[0]) begin
      w = mem_word(mreg[1] * 256 + mreg[0]);
      mreg[2] = w & 8'hff;
      mreg[3] = w >> 8;
    end
    wb(1'b1, CMD_OFS, {14'h0, nop, we, d, 5'h0, idx});
    for (i = 0; i < 200; i++) begin
      wb(1'b0, STAT_OFS, 32'h0);
      if (rd[ST_BUSY_BIT] === 1'b0) break;
    end
    if (i == 200) begin
      n_fail++;
      end_sim();
    end
  endtask : cmd
  task rdreg(input logic [2:0] idx);
    cmd(idx, 8'h00, 1'b0, 1'b0);
    wb(1'b0, STAT_OFS, 32'h0);
  endtask : rdreg
  // keys, optional stray access, go, two slots after
  task unlock(input logic [7:0] c, input bit stray, input bit vw);
    cmd(UNLOCK_IDX, UNLOCK_KEY1, 1'b1, 1'b0);
    if (stray) cmd(ADDR_LOW_IDX, 8'(mreg[0]), 1'b1, 1'b0);
    cmd(UNLOCK_IDX, UNLOCK_KEY2, 1'b1, 1'b0);
    cmd(CTRL1_IDX, c, 1'b1, 1'b0);
    skip = vw;
    cmd(WORD_LOW_IDX, 8'h5a, vw, !vw);
    skip = 0;
    cmd(3'h0, 8'h00, 1'b0, 1'b1);
  endtask : unlock
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    CLK = 0;
    RESET = 1;
    {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I} = '0;
    WB_SEL_I = 4'hf;
    ARR_WIDX = '0;
    foreach (mreg[i]) mreg[i] = 0;
    void'($urandom(32'h8c96));
    repeat (16) @(posedge CLK);
    RESET <= 1'b0;
    // slots free-run from reset, step past the first one
    repeat (2) @(posedge CLK);
    wb(1'b0, STAT_OFS, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, 8'h40, 32'hffffffff);
    rdreg(CTRL1_IDX);
    chk(rd[15:8], 8'h00);
    rdreg(UNLOCK_IDX);
    chk(rd[15:8], 8'h00);
    $display("test reset done");
    for (k = 0; k < 3; k++) begin
      a = (k == 0) ? 16'h7fff : ($urandom & 16'h7fff);
      cmd(ADDR_LOW_IDX, 8'(a), 1'b1, 1'b0);
      cmd(ADDR_HIGH_IDX, 8'(a >> 8), 1'b1, 1'b0);
      cmd(CTRL1_IDX, 8'h01, 1'b1, 1'b0);
      cmd(3'h0, 8'h00, 1'b0, 1'b1);
      cmd(3'h0, 8'h00, 1'b0, 1'b1);
      rdreg(WORD_LOW_IDX);
      chk(rd[15:8], mreg[2]);
      chk(rd_cnt, k + 1);
      rdreg(WORD_HIGH_IDX);
      chk(rd[15:8], mreg[3]);
      rdreg(CTRL1_IDX);
      chk(rd[15:8], mreg[4]);
      cmd(ADDR_LOW_IDX, 8'(a + 1), 1'b1, 1'b0);
      rdreg(WORD_LOW_IDX);
      chk(rd[15:8], mreg[2]);
    end
    $display("test read done");
    a = $urandom;
    w = $urandom & 16'h3fff;
    cmd(CTRL1_IDX, 8'h24, 1'b1, 1'b0);
    cmd(ADDR_LOW_IDX, 8'(a), 1'b1, 1'b0);
    cmd(WORD_LOW_IDX, 8'(w), 1'b1, 1'b0);
    cmd(WORD_HIGH_IDX, 8'(w >> 8), 1'b1, 1'b0);
    h = hold_cnt;
    unlock(8'h26, 0, 0);
    chk(hold_cnt, h);
    ARR_WIDX <= 5'(a);
    repeat (2) @(posedge CLK);
    chk(ARR_WDATA, w);
    $display("test latch done");
    e = erase_cnt;
    cmd(CTRL1_IDX, 8'h14, 1'b1, 1'b0);
    unlock(8'h16, 1, 0);
    chk(erase_cnt, e);
    cmd(CTRL1_IDX, 8'h10, 1'b1, 1'b0);
    unlock(8'h12, 0, 1);
    chk(erase_cnt, e);
    chk(ARR_WDATA, w);
    rdreg(WORD_LOW_IDX);
    chk(rd[15:8], mreg[2]);
    wb(1'b0, STAT_OFS, 32'h0);
    chk(rd[ST_VOID_BIT], 1'b1);
    wb(1'b1, STAT_OFS, 32'h4);
    wb(1'b0, STAT_OFS, 32'h0);
    chk(rd[ST_VOID_BIT], 1'b0);
    $display("test refused done");
    a = $urandom & 16'h7fff;
    cmd(ADDR_LOW_IDX, 8'(a), 1'b1, 1'b0);
    cmd(ADDR_HIGH_IDX, 8'(a >> 8), 1'b1, 1'b0);
    cmd(CTRL1_IDX, 8'h14, 1'b1, 1'b0);
    h = hold_cnt;
    unlock(8'h16, 0, 0);
    chk(erase_cnt, e + 1);
    chk(erase_adr[14:5], a[14:5]);
    chk(hold_cnt >= h + ECYC, 1);
    chk(ARR_WDATA, LATCH_BLANK);
    rdreg(CTRL1_IDX);
    chk(rd[15:8], mreg[4]);
    $display("test erase done");
    b = busy_cnt;
    h = hold_cnt;
    cmd(CTRL1_IDX, 8'h04, 1'b1, 1'b0);
    unlock(8'h06, 0, 0);
    chk(prog_cnt, 1);
    chk(hold_cnt >= h + ECYC, 1);
    chk(busy_cnt >= b + ECYC, 1);
    chk(erase_cnt, e + 1);
    rdreg(CTRL1_IDX);
    chk(rd[15:8], mreg[4]);
    $display("test program done");
    end_sim();
  end
endmodule : tb_program_flash_self_access
